// ---- memdec_pkg.sv ----
// package of constants and carrier types for the memory-space decoder
// Notes on behaviour
// - drive upper address byte on high port during 16-bit external moves
// - low port multiplexes address/data and enables pull-ups while accessing external memory
// - program-store strobe pulses twice per machine cycle on external fetch
// - skip two program-store pulses per external data access cycle
// - program-store strobe stays high when no external fetch runs
// - address-latch pulses every six periods, one of the two skipped per external data access cycle
// - latch-pulse-mute bit, power control bit 5, reset clear, holds latch low
// - external data moves reaching external memory still pulse the latch
// - in mute mode latch is high in idle, low in power-down
// - internal execution fetching beyond internal memory pulses latch regardless of mute
// - external execution always pulses latch, mute bit ignored
// - board holds access select during reset; device latches it, ignores later
// - select high: fetch to 7FFF internal, 8000 to FFFF external
// - select low: every fetch comes from external program memory
// - security active: refuse internal code reads from tests or external code
// - RAM 0-127 direct and indirect, 128-255 indirect only
// - direct addresses 128-255 decode to special registers, never indirectly
// - extra RAM enabled: data-pointer moves 0-767 go to extra RAM
// - register-pointer moves use page select as upper address into extra RAM
// - internal execution leaves ports and strobes untouched on extra RAM access
// - data-pointer moves above 767 run a standard external bus cycle
// - extra RAM enabled: register-pointer moves never reach external memory
// - four banks of 8 registers at 0-31, bit area at 32-47
// - page select low two bits pick page; code 11 invalid; resets to 00
// - extra-RAM disable bit in power control; set routes moves externally
package memdec_pkg;
  localparam int          PHASES_PER_CYCLE = 12;
  localparam int          ALE_PERIOD       = 6;
  localparam logic [15:0] INT_CODE_TOP     = 16'h7FFF;
  localparam logic [15:0] XRAM_TOP         = 16'h02FF;
  localparam logic [7:0]  SFR_BASE         = 8'h80;
  localparam logic [7:0]  BANK_TOP         = 8'h1F;
  localparam logic [7:0]  BIT_AREA_LO      = 8'h20;
  localparam logic [7:0]  BIT_AREA_HI      = 8'h2F;
  localparam int          MUTE_BIT         = 5;
  localparam int          XDIS_BIT         = 6;
  localparam logic [7:0]  POWER_CTRL_REG_RESET       = 8'h00;
  localparam logic [1:0]  PAGE_RESET       = 2'b00;
  localparam logic [1:0]  PAGE_RESERVED    = 2'b11;

  typedef enum logic [2:0] {TGT_NONE, TGT_IRAM, TGT_SFR, TGT_XRAM, TGT_EXT} target_type;
  typedef enum logic [1:0] {ACC_DIRECT, ACC_INDIRECT, ACC_EXTERNAL_MOVE_OP_DATA_POINTER16, ACC_EXTERNAL_MOVE_OP_RI} access_type;

  typedef struct packed {
    logic       valid;
    access_type kind;
    logic       write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dreq_type;

  typedef struct packed {
    target_type target;
    logic [9:0] localAddr;
    logic       bitArea;
    logic [1:0] bank;
  } droute_type;

  typedef struct packed {
    logic [7:0] lowOut;
    logic       lowOeN;
    logic       lowPullup;
    logic [7:0] highOut;
    logic       highDrive;
    logic       wrStrobeN;
    logic       rdStrobeN;
  } bus_type;
endpackage : memdec_pkg

// ---- data_route.sv ----
// combinational decoder of data-space accesses
`timescale 1ns/10ps
`default_nettype none
module data_route (
  input  wire memdec_pkg::dreq_type   req,
  input  wire logic                   extraRamDisable,
  input  wire logic [1:0]             pageSel,
  input  wire logic [1:0]             bankSel,
  output memdec_pkg::droute_type      route
);
  import memdec_pkg::*;
  always_comb begin
    route           = '0;
    route.target    = TGT_NONE;
    route.bank      = bankSel;
    route.localAddr = {2'b00, req.addr[7:0]};
    route.bitArea   = (req.addr[7:0] >= BIT_AREA_LO) && (req.addr[7:0] <= BIT_AREA_HI);
    if (!req.valid) begin
      route.target = TGT_NONE;
    end else if (req.kind == ACC_DIRECT) begin
      route.target = (req.addr[7:0] >= SFR_BASE) ? TGT_SFR : TGT_IRAM;
    end else if (req.kind == ACC_INDIRECT) begin
      route.target = TGT_IRAM;
    end else if (req.kind == ACC_EXTERNAL_MOVE_OP_DATA_POINTER16) begin
      if (!extraRamDisable && req.addr <= XRAM_TOP) begin
        route.target    = TGT_XRAM;
        route.localAddr = req.addr[9:0];
      end else begin
        route.target = TGT_EXT;
      end
    end else begin
      if (extraRamDisable) begin
        route.target = TGT_EXT;
      end else if (pageSel == PAGE_RESERVED) begin
        route.target = TGT_NONE;
      end else begin
        route.target    = TGT_XRAM;
        route.localAddr = {pageSel, req.addr[7:0]};
      end
    end
  end
endmodule : data_route
`default_nettype wire

// ---- strobe_timer.sv ----
// phase counter producing latch and program-store pulse slots
`timescale 1ns/10ps
`default_nettype none
module strobe_timer #(
  parameter int PHASES = memdec_pkg::PHASES_PER_CYCLE
) (
  input  wire logic clk,
  input  wire logic rstn,
  output logic [3:0] phase,
  output logic       latchSlot,
  output logic       storeSlot,
  output logic       cycleEnd
);
  import memdec_pkg::*;
  logic [3:0] phase_r;
  logic [3:0] phase_nxt;
  always_comb begin
    phase_nxt = (phase_r == 4'(PHASES - 1)) ? 4'h0 : phase_r + 4'h1;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_r <= 4'h0;
    end else begin
      phase_r <= phase_nxt;
    end
  end
  assign phase     = phase_r;
  // one latch slot every six periods, store slot two periods later
  assign latchSlot = (phase_r == 4'h0) || (phase_r == 4'(ALE_PERIOD));
  assign storeSlot = (phase_r == 4'h2) || (phase_r == 4'(ALE_PERIOD + 2));
  assign cycleEnd  = (phase_r == 4'(PHASES - 1));
endmodule : strobe_timer
`default_nettype wire

// ---- memory_space_decoder_ext_bus.sv ----
// top: program/data space decoding and external bus strobes
`timescale 1ns/10ps
`default_nettype none
module memory_space_decoder_ext_bus (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  extAccessSelPin,
  input  wire logic                  securityOn,
  input  wire logic                  testRead,
  input  wire logic [15:0]           fetchAddr,
  input  wire logic                  fetchReq,
  input  wire logic                  codeMoveReq,
  input  wire logic [15:0]           codeMoveAddr,
  input  wire memdec_pkg::dreq_type  dataReq,
  input  wire logic [1:0]            bankSel,
  input  wire logic                  pconWrite,
  input  wire logic [7:0]            pconWdata,
  input  wire logic                  pageWrite,
  input  wire logic [7:0]            pageWdata,
  input  wire logic                  idleMode,
  input  wire logic                  powerDown,
  input  wire logic [7:0]            lowPortIn,
  output logic [7:0]                 powerCtrlReg,
  output logic [7:0]                 extraRamPageSel,
  output logic                       extExecLatched,
  output logic                       fetchInternal,
  output logic                       codeReadRefused,
  output memdec_pkg::droute_type     dataRoute,
  output memdec_pkg::bus_type        bus,
  output logic [7:0]                 extReadData,
  output logic                       addrLatchOut,
  output logic                       progStoreStrobeN
);
  import memdec_pkg::*;

  logic [1:0]  eaSync_r;
  logic        eaHigh_r;
  logic        eaHigh_nxt;
  logic        resetSeen_r;
  logic [7:0]  power_ctrl_reg_r;
  logic [7:0]  power_ctrl_reg_nxt;
  logic [1:0]  page_r;
  logic [1:0]  page_nxt;
  logic [3:0]  phase;
  logic        latchSlot;
  logic        storeSlot;
  logic        cycleEnd;
  logic        extDataCycle_r;
  logic        extDataCycle_nxt;
  dreq_type    heldReq_r;
  dreq_type    heldReq_nxt;
  bus_type     bus_r;
  bus_type     bus_nxt;
  logic        ale_r;
  logic        ale_nxt;
  logic        prog_store_strobe_r;
  logic        prog_store_strobe_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic        extFetch;
  logic        mute;
  droute_type  route;

  // pin comes from the board, so synchronise before use
  // no reset here: the pin must be sampled while reset is held, else release always latches zero
  always_ff @(posedge clk) begin
    eaSync_r <= {eaSync_r[0], extAccessSelPin};
  end

  // capture once, on the first edge after release; the pin is ignored thereafter
  always_comb begin
    eaHigh_nxt = resetSeen_r ? eaHigh_r : eaSync_r[1];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eaHigh_r    <= 1'b0;
      resetSeen_r <= 1'b0;
    end else begin
      eaHigh_r    <= eaHigh_nxt;
      resetSeen_r <= 1'b1;
    end
  end

  // power control and page select registers
  always_comb begin
    power_ctrl_reg_nxt = pconWrite ? pconWdata : power_ctrl_reg_r;
    page_nxt = pageWrite ? pageWdata[1:0] : page_r;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      power_ctrl_reg_r <= POWER_CTRL_REG_RESET;
      page_r <= PAGE_RESET;
    end else begin
      power_ctrl_reg_r <= power_ctrl_reg_nxt;
      page_r <= page_nxt;
    end
  end

  strobe_timer #(
    .PHASES (PHASES_PER_CYCLE)
  ) timer (
    .clk       (clk),
    .rstn      (rstn),
    .phase     (phase),
    .latchSlot (latchSlot),
    .storeSlot (storeSlot),
    .cycleEnd  (cycleEnd)
  );

  data_route router (
    .req             (dataReq),
    .extraRamDisable (power_ctrl_reg_r[XDIS_BIT]),
    .pageSel         (page_r),
    .bankSel         (bankSel),
    .route           (route)
  );

  // program space decode
  assign fetchInternal = eaHigh_r && (fetchAddr <= INT_CODE_TOP);
  assign extFetch      = fetchReq && !fetchInternal;
  assign mute          = power_ctrl_reg_r[MUTE_BIT];

  // with security on, code reads from external space or test modes see nothing of internal code
  always_comb begin
    codeReadRefused = securityOn && (testRead || (codeMoveReq && !fetchInternal
                      && eaHigh_r && codeMoveAddr <= INT_CODE_TOP));
  end

  // external data cycle spans one machine cycle, taken at cycle boundary
  always_comb begin
    extDataCycle_nxt = extDataCycle_r;
    heldReq_nxt      = heldReq_r;
    if (cycleEnd) begin
      extDataCycle_nxt = dataReq.valid && (route.target == TGT_EXT);
      heldReq_nxt      = dataReq;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      extDataCycle_r <= 1'b0;
      heldReq_r      <= '0;
    end else begin
      extDataCycle_r <= extDataCycle_nxt;
      heldReq_r      <= heldReq_nxt;
    end
  end

  // strobes and bus drive
  always_comb begin
    ale_nxt  = 1'b0;
    prog_store_strobe_nxt = 1'b1;
    if (powerDown && mute) begin
      ale_nxt = 1'b0;
    end else if (idleMode && mute) begin
      ale_nxt = 1'b1;
    end else if (extDataCycle_r) begin
      // one latch pulse for the data address, the fetch slots are dropped
      ale_nxt = (phase == 4'(ALE_PERIOD));
    end else if (!mute || !eaHigh_r || extFetch) begin
      ale_nxt = latchSlot;
    end else begin
      ale_nxt = 1'b0;
    end
    if (extFetch && !extDataCycle_r && !idleMode && !powerDown) begin
      prog_store_strobe_nxt = !storeSlot;
    end
  end

  always_comb begin
    bus_nxt           = '0;
    bus_nxt.lowOeN    = 1'b1;
    bus_nxt.wrStrobeN = 1'b1;
    bus_nxt.rdStrobeN = 1'b1;
    rdata_nxt         = rdata_r;
    if (extDataCycle_r) begin
      bus_nxt.lowPullup = 1'b1;
      bus_nxt.highDrive = (heldReq_r.kind == ACC_EXTERNAL_MOVE_OP_DATA_POINTER16);
      bus_nxt.highOut   = heldReq_r.addr[15:8];
      if (phase < 4'(ALE_PERIOD + 1)) begin
        bus_nxt.lowOut = heldReq_r.addr[7:0];
        bus_nxt.lowOeN = 1'b0;
      end else if (heldReq_r.write) begin
        bus_nxt.lowOut    = heldReq_r.wdata;
        bus_nxt.lowOeN    = 1'b0;
        bus_nxt.wrStrobeN = (phase == 4'(PHASES_PER_CYCLE - 1));
      end else begin
        bus_nxt.rdStrobeN = (phase == 4'(PHASES_PER_CYCLE - 1));
        if (phase == 4'(PHASES_PER_CYCLE - 2)) begin
          rdata_nxt = lowPortIn;
        end
      end
    end else if (extFetch) begin
      bus_nxt.lowPullup = 1'b1;
      bus_nxt.highDrive = 1'b1;
      bus_nxt.highOut   = fetchAddr[15:8];
      bus_nxt.lowOut    = fetchAddr[7:0];
      bus_nxt.lowOeN    = !latchSlot;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ale_r   <= 1'b0;
      prog_store_strobe_r  <= 1'b1;
      bus_r   <= '{lowOut: 8'h00, lowOeN: 1'b1, lowPullup: 1'b0, highOut: 8'h00,
                   highDrive: 1'b0, wrStrobeN: 1'b1, rdStrobeN: 1'b1};
      rdata_r <= 8'h00;
    end else begin
      ale_r   <= ale_nxt;
      prog_store_strobe_r  <= prog_store_strobe_nxt;
      bus_r   <= bus_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign powerCtrlReg     = power_ctrl_reg_r;
  assign extraRamPageSel  = {6'b00_0000, page_r};
  assign extExecLatched   = !eaHigh_r;
  assign dataRoute        = route;
  assign bus              = bus_r;
  assign extReadData      = rdata_r;
  assign addrLatchOut     = ale_r;
  assign progStoreStrobeN = prog_store_strobe_r;
endmodule : memory_space_decoder_ext_bus
`default_nettype wire

// ---- memdec_sva.sv ----
// checker: strobe timing and space decoding of the memory decoder top
`timescale 1ns/10ps
`default_nettype none
module memdec_sva (
  input wire logic                   clk,
  input wire logic                   rstn,
  input wire logic                   securityOn,
  input wire logic                   testRead,
  input wire logic [15:0]            fetchAddr,
  input wire logic                   fetchReq,
  input wire memdec_pkg::dreq_type   dataReq,
  input wire logic                   idleMode,
  input wire logic                   powerDown,
  input wire logic [7:0]             powerCtrlReg,
  input wire logic [7:0]             extraRamPageSel,
  input wire logic                   extExecLatched,
  input wire logic                   fetchInternal,
  input wire logic                   codeReadRefused,
  input wire memdec_pkg::droute_type dataRoute,
  input wire memdec_pkg::bus_type    bus,
  input wire logic                   addrLatchOut,
  input wire logic                   progStoreStrobeN
);
  import memdec_pkg::*;
  logic       xb;
  logic [4:0] calm_r;
  logic [4:0] calm_nxt;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  assign xb = !bus.rdStrobeN || !bus.wrStrobeN;
  // quiet time since the last data move, so a move's own latch pulse is not taken for noise
  always_comb begin
    calm_nxt = calm_r + 5'h01;
    if (xb || dataReq.valid) begin
      calm_nxt = 5'h00;
    end else if (calm_r == 5'h1F) begin
      calm_nxt = calm_r;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      calm_r <= 5'h00;
    end else begin
      calm_r <= calm_nxt;
    end
  end
  a_prog_store_strobe_idle: assert property ((!fetchReq || fetchInternal) [*3] |-> progStoreStrobeN)
    else $error("program strobe low without external fetch");
  // a data cycle drives the address on the low port and drops both fetch pulses
  a_prog_store_strobe_pair: assert property ($fell(progStoreStrobeN) && fetchReq && !fetchInternal
    |-> ##6 ($fell(progStoreStrobeN) || !fetchReq || fetchInternal || !bus.lowOeN))
    else $error("program strobe not pulsed twice per machine cycle");
  a_prog_store_strobe_data: assert property (xb |-> progStoreStrobeN)
    else $error("program strobe during data bus cycle");
  a_ale_data: assert property (xb |-> !addrLatchOut && bus.lowPullup)
    else $error("latch pulse or pull-up wrong in data phase");
  a_ale_period: assert property ($rose(addrLatchOut) && fetchReq && !fetchInternal && !dataReq.valid
    |-> ##6 ($rose(addrLatchOut) || !fetchReq || fetchInternal || dataReq.valid))
    else $error("latch pulse spacing not six periods");
  a_mute_quiet: assert property ((calm_r > 5'h18 && powerCtrlReg[MUTE_BIT] && fetchInternal && !idleMode) [*3]
    |-> !addrLatchOut)
    else $error("latch pulses while muted");
  a_mute_idle: assert property ((powerCtrlReg[MUTE_BIT] && idleMode && !powerDown) [*2] |-> addrLatchOut)
    else $error("latch not high in idle while muted");
  a_mute_pd: assert property ((powerCtrlReg[MUTE_BIT] && powerDown) [*2] |-> !addrLatchOut)
    else $error("latch not low in power-down while muted");
  a_sel_hold: assert property ($past(rstn, 2) |-> $stable(extExecLatched))
    else $error("execution select changed after reset");
  a_fetch_map: assert property (fetchReq |-> fetchInternal == (!extExecLatched && fetchAddr <= INT_CODE_TOP))
    else $error("fetch source decoded wrongly");
  a_code_refuse: assert property ((securityOn && testRead) || !securityOn |-> codeReadRefused == securityOn)
    else $error("code read protection wrong");
  a_direct_map: assert property (dataReq.valid && dataReq.kind == ACC_DIRECT
    |-> dataRoute.target == (dataReq.addr[7:0] >= SFR_BASE ? TGT_SFR : TGT_IRAM))
    else $error("direct access decoded to wrong space");
  a_ri_route: assert property (dataReq.valid && dataReq.kind == ACC_EXTERNAL_MOVE_OP_RI && !powerCtrlReg[XDIS_BIT]
    |-> dataRoute.target == (extraRamPageSel[1:0] == PAGE_RESERVED ? TGT_NONE : TGT_XRAM))
    else $error("pointer move routed wrongly");
endmodule : memdec_sva
bind memory_space_decoder_ext_bus memdec_sva i_sva (.clk, .rstn, .securityOn, .testRead, .fetchAddr, .fetchReq,
  .dataReq, .idleMode, .powerDown, .powerCtrlReg, .extraRamPageSel, .extExecLatched, .fetchInternal,
  .codeReadRefused, .dataRoute, .bus, .addrLatchOut, .progStoreStrobeN);
`default_nettype wire

// ---- ext_mem_model.sv ----
// external data memory behind an address latch
`timescale 1ns/10ps
`default_nettype none
module ext_mem_model (
  input  wire logic                clk,
  input  wire logic                ale,
  input  wire memdec_pkg::bus_type bus,
  output logic [7:0]               rdData,
  output logic [7:0]               hiAddr
);
  import memdec_pkg::*;
  logic [7:0] mem [0:255];
  logic [7:0] lowAddr;
  logic [7:0] lastOut;
  // address taken on the clock, so the falling latch pulse never races the data on the low port
  always @(posedge clk) if (ale) lowAddr <= bus.lowOut;
  always @(posedge clk) begin
    if (!bus.wrStrobeN) mem[lowAddr] <= bus.lowOut;
    if (!bus.wrStrobeN || !bus.rdStrobeN) hiAddr <= bus.highOut;
    if (!bus.lowOeN) lastOut <= bus.lowOut;
  end
  // a released port shows the pull-up level, else the inverse of the last value
  assign rdData = !bus.rdStrobeN ? mem[lowAddr] : (bus.lowPullup ? 8'hFF : ~lastOut);
endmodule : ext_mem_model
`default_nettype wire

// ---- tb_top.sv ----
// testbench: decode, strobe timing and external moves of the memory decoder
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import memdec_pkg::*;
  logic        clk, rstn, extAccessSelPin, securityOn, testRead, fetchReq, codeMoveReq, touched;
  logic        pconWrite, pageWrite, idleMode, powerDown, extExecLatched, fetchInternal, aleQ, psQ;
  logic        codeReadRefused, addrLatchOut, progStoreStrobeN;
  logic [15:0] fetchAddr, codeMoveAddr;
  logic [7:0]  pconWdata, pageWdata, lowPortIn, powerCtrlReg, extraRamPageSel, extReadData;
  logic [1:0]  bankSel;
  dreq_type    dataReq;
  droute_type  dataRoute;
  bus_type     bus;
  int          errors, checks_done, aleN, psenFalls, cyc;
  memory_space_decoder_ext_bus i_dut (.*);
  ext_mem_model i_mem (.clk(clk), .ale(addrLatchOut), .bus(bus), .rdData(lowPortIn), .hiAddr());
  always #12.5 clk = ~clk;
  always @(negedge clk) begin
    if (addrLatchOut && !aleQ) aleN++;
    if (!progStoreStrobeN && psQ) psenFalls++;
    if (!bus.rdStrobeN || !bus.wrStrobeN) touched = 1;
    aleQ = addrLatchOut;
    psQ = progStoreStrobeN;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task automatic rst(input logic pin);
    rstn = 0;
    extAccessSelPin = pin;
    tick(6);
    rstn = 1;
    tick(2);
  endtask : rst
  task automatic setReg(input logic pg, input logic [7:0] d);
    {pageWrite, pconWrite, pageWdata, pconWdata} = {pg, !pg, d, d};
    tick(1);
    {pageWrite, pconWrite} = 2'b00;
  endtask : setReg
  // request stays up for one machine cycle, so exactly one sample is taken
  task automatic mv(input logic w, input logic [15:0] a, input logic [7:0] d);
    dataReq = '{1'b1, ACC_EXTERNAL_MOVE_OP_DATA_POINTER16, w, a, d};
    tick(12);
    dataReq.valid = 0;
    tick(24);
  endtask : mv
  task automatic rte(input access_type k, input logic [15:0] a, input target_type t);
    dataReq = '{1'b1, k, 1'b0, a, 8'h00};
    #1 chk("target", 16'(t), 16'(dataRoute.target));
    tick(1);
  endtask : rte
  task automatic win();
    tick(12);
    {aleN, psenFalls} = '0;
    tick(24);
  endtask : win
  initial begin
    {clk, rstn, securityOn, testRead, fetchReq, codeMoveReq, pconWrite, pageWrite, idleMode, powerDown} = '0;
    {fetchAddr, codeMoveAddr, pconWdata, pageWdata, bankSel, dataReq, aleQ, psQ, touched} = '0;
    {errors, checks_done, aleN, psenFalls, cyc} = '0;
    rst(1'b1);
    chk("power_ctrl_reg", 8'h00, powerCtrlReg);
    chk("page", 8'h00, extraRamPageSel);
    chk("prog_store_strobe", 1, progStoreStrobeN);
    extAccessSelPin = 0;
    fetchReq = 1;
    fetchAddr = 16'h7FFF;
    tick(1);
    chk("fint", 1, fetchInternal);
    chk("latched", 0, extExecLatched);
    fetchAddr = 16'h8000;
    win();
    chk("prog_store_strobe", 4, psenFalls);
    chk("ale", 4, aleN);
    fetchReq = 0;
    win();
    chk("prog_store_strobe", 0, psenFalls);
    $display("test fetch done");
    bankSel = 2'b10;
    rte(ACC_DIRECT, 16'h002F, TGT_IRAM);
    chk("bitarea", 1, dataRoute.bitArea);
    chk("bank", 2'b10, dataRoute.bank);
    rte(ACC_DIRECT, 16'h0080, TGT_SFR);
    rte(ACC_INDIRECT, 16'h00FF, TGT_IRAM);
    rte(ACC_EXTERNAL_MOVE_OP_DATA_POINTER16, 16'h02FF, TGT_XRAM);
    chk("local", 10'h2FF, dataRoute.localAddr);
    setReg(1, 8'hFE);
    chk("page", 8'h02, extraRamPageSel);
    rte(ACC_EXTERNAL_MOVE_OP_RI, 16'h0034, TGT_XRAM);
    chk("local", 10'h234, dataRoute.localAddr);
    setReg(1, 8'h03);
    rte(ACC_EXTERNAL_MOVE_OP_RI, 16'h0034, TGT_NONE);
    dataReq.valid = 0;
    tick(14);
    chk("touched", 0, touched);
    setReg(0, 8'h40);
    rte(ACC_EXTERNAL_MOVE_OP_RI, 16'h0034, TGT_EXT);
    rte(ACC_EXTERNAL_MOVE_OP_DATA_POINTER16, 16'h0100, TGT_EXT);
    setReg(0, 8'h00);
    rte(ACC_EXTERNAL_MOVE_OP_DATA_POINTER16, 16'h0300, TGT_EXT);
    dataReq.valid = 0;
    tick(14);
    $display("test route done");
    mv(1, 16'h12C4, 8'hA5);
    chk("mem", 8'hA5, i_mem.mem[8'hC4]);
    chk("high", 8'h12, i_mem.hiAddr);
    mv(0, 16'h12C4, 8'h00);
    chk("rdata", 8'hA5, extReadData);
    $display("test bus done");
    setReg(0, 8'h20);
    chk("power_ctrl_reg", 8'h20, powerCtrlReg);
    fetchReq = 1;
    fetchAddr = 16'h0100;
    win();
    chk("ale", 0, aleN);
    fetchAddr = 16'h8000;
    win();
    chk("ale", 4, aleN);
    fetchReq = 0;
    fetchAddr = 16'h0100;
    tick(2);
    aleN = 0;
    mv(1, 16'h4400, 8'h3C);
    chk("ale", 1, aleN);
    idleMode = 1;
    tick(3);
    chk("ale", 1, addrLatchOut);
    {idleMode, powerDown} = 2'b01;
    tick(3);
    chk("ale", 0, addrLatchOut);
    powerDown = 0;
    {securityOn, testRead} = 2'b11;
    tick(1);
    chk("refused", 1, codeReadRefused);
    {testRead, codeMoveReq, codeMoveAddr, fetchAddr, fetchReq} = {2'b01, 16'h0100, 16'h8000, 1'b1};
    tick(1);
    chk("refused", 1, codeReadRefused);
    securityOn = 0;
    tick(1);
    chk("refused", 0, codeReadRefused);
    $display("test mute done");
    rst(1'b0);
    extAccessSelPin = 1;
    fetchAddr = 16'h0100;
    setReg(0, 8'h20);
    win();
    chk("latched", 1, extExecLatched);
    chk("fint", 0, fetchInternal);
    chk("ale", 4, aleN);
    chk("prog_store_strobe", 4, psenFalls);
    {aleN, psenFalls} = '0;
    mv(1, 16'h1234, 8'h5A);
    chk("prog_store_strobe", 4, psenFalls);
    chk("ale", 5, aleN);
    chk("mem", 8'h5A, i_mem.mem[8'h34]);
    $display("test external done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
